// >>> pedc_map.svh
`ifndef PEDC_MAP_SVH
`define PEDC_MAP_SVH
`define PEDC_OFF_PHY_CONTROL_TWO 12'h000
`define PEDC_OFF_IRQ_STATUS 12'h004
`define PEDC_OFF_IRQ_MASK 12'h008
`define PEDC_OFF_PHY_STATUS 12'h00c
`define PEDC_BIT_SLEEP_EN 13
`define PEDC_BIT_WAKE_LOW 11
`define PEDC_BIT_FORCE_LINK 2
`define PEDC_BIT_ENERGY 1
`define PEDC_CTRL_WMASK 16'h2804
`define PEDC_CTRL_RESET 16'h0000
`define PEDC_IRQ_BITS 3
`endif

// >>> pedc_pkg.sv
package pedc_pkg;
    typedef enum logic [1:0] {
        PEDC_PWR_ON,
        PEDC_PWR_SLEEP
    } pedc_pwr_t;
endpackage

// >>> pedc_top.sv
// What this block does
// - energy sleep enable makes phy power follow the energy present flag.
// - wake threshold low bit selects the reduced energy detection threshold.
// - force link up raises link at once, only in 100 Mbps operation.
// - energy present flag is read only and resets to one.
// - reserved bits ignore writes and read zero; writable fields reset to zero.
// - flag sets when a signal is sensed on the receive pair.
// - while asleep and unlinked, transmit requests are held off indefinitely.
`timescale 1ns/10ps
`include "pedc_map.svh"
module pedc_top
    import pedc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // phy side
    input wire logic receive_pair_input,
    input wire logic speed_100,
    input wire logic link_partner_ok,
    input wire logic transmit_request,
    output logic phy_power_down,
    output logic wake_threshold_low,
    output logic link_up,
    output logic transmit_allowed,
    // interrupt
    output logic irq
);
    logic [15:0] ctrl_q;
    logic [2:0] rx_sync_q;
    logic energy_q;
    logic [`PEDC_IRQ_BITS-1:0] status_q;
    logic [`PEDC_IRQ_BITS-1:0] mask_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic link_prev_q;
    logic energy_prev_q;
    pedc_pwr_t pwr_q;
    logic [31:0] rdata_d;
    logic [`PEDC_IRQ_BITS-1:0] events;
    logic addr_phase;
    logic link_now;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_ctrl = wr_pend_q && wr_addr_q == `PEDC_OFF_PHY_CONTROL_TWO;
    assign wr_status = wr_pend_q && wr_addr_q == `PEDC_OFF_IRQ_STATUS;
    assign wr_mask = wr_pend_q && wr_addr_q == `PEDC_OFF_IRQ_MASK;

    // write data arrives one cycle after its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `PEDC_CTRL_RESET;
        end else if (wr_pend_q && wr_addr_q == `PEDC_OFF_PHY_CONTROL_TWO) begin
            ctrl_q <= hwdata[15:0] & `PEDC_CTRL_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= '0;
        end else if (wr_pend_q && wr_addr_q == `PEDC_OFF_IRQ_MASK) begin
            mask_q <= hwdata[`PEDC_IRQ_BITS-1:0];
        end
    end

    // three stage sampling of the analog detector; a change counts when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sync_q <= 3'h7;
            energy_q <= 1'b1;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], receive_pair_input};
            if (rx_sync_q[1] == rx_sync_q[2]) begin
                energy_q <= rx_sync_q[2];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_q <= PEDC_PWR_ON;
        end else if (ctrl_q[`PEDC_BIT_SLEEP_EN] && !energy_q) begin
            pwr_q <= PEDC_PWR_SLEEP;
        end else begin
            pwr_q <= PEDC_PWR_ON;
        end
    end

    assign link_now = (speed_100 && ctrl_q[`PEDC_BIT_FORCE_LINK]) ||
        (link_partner_ok && pwr_q == PEDC_PWR_ON);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_power_down <= 1'b0;
        end else begin
            phy_power_down <= (pwr_q == PEDC_PWR_SLEEP);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_threshold_low <= 1'b0;
        end else begin
            wake_threshold_low <= ctrl_q[`PEDC_BIT_WAKE_LOW];
        end
    end

    // link_prev_q follows link_now so that a link change raises its event bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_up <= 1'b0;
            link_prev_q <= 1'b0;
        end else begin
            link_up <= link_now;
            link_prev_q <= link_now;
        end
    end

    // a held request is simply not granted; it stays pending at the source
    // link_now already excludes a sleeping phy unless the link is forced in 100 Mbps operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_allowed <= 1'b0;
        end else begin
            transmit_allowed <= transmit_request && link_now;
        end
    end

    // same reset value as the energy flag, so no false edge follows reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            energy_prev_q <= 1'b1;
        end else begin
            energy_prev_q <= energy_q;
        end
    end

    // events: link change, energy rise, energy fall
    assign events = {energy_prev_q && !energy_q, !energy_prev_q && energy_q, link_prev_q != link_now};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= '0;
        end else if (wr_pend_q && wr_addr_q == `PEDC_OFF_IRQ_STATUS) begin
            // a new event wins over a simultaneous clear
            status_q <= (status_q & ~hwdata[`PEDC_IRQ_BITS-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    assign irq = |(status_q & mask_q);

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (haddr)
            `PEDC_OFF_PHY_CONTROL_TWO: begin
                rdata_d[15:0] = (ctrl_q & `PEDC_CTRL_WMASK) | (16'h0001 << `PEDC_BIT_ENERGY);
                rdata_d[`PEDC_BIT_ENERGY] = energy_q;
            end
            `PEDC_OFF_IRQ_STATUS: rdata_d[`PEDC_IRQ_BITS-1:0] = status_q;
            `PEDC_OFF_IRQ_MASK: rdata_d[`PEDC_IRQ_BITS-1:0] = mask_q;
            `PEDC_OFF_PHY_STATUS: rdata_d[2:0] = {transmit_allowed, link_up, phy_power_down};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rdata_d;
        end
    end

    // counts how long a pending request has waited; saturates so it never wraps
    logic [3:0] tx_wait_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wait_q <= 4'h0;
        end else if (transmit_request && !transmit_allowed) begin
            tx_wait_q <= (tx_wait_q == 4'hf) ? tx_wait_q : 4'(tx_wait_q + 4'h1);
        end else begin
            tx_wait_q <= 4'h0;
        end
    end

    sleep_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q[`PEDC_BIT_SLEEP_EN] && !energy_q) |=> pwr_q == PEDC_PWR_SLEEP)
        else $error("phy did not sleep without energy");
    sleep_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q[`PEDC_BIT_SLEEP_EN] |=> ##1 !phy_power_down)
        else $error("phy asleep with sleep disabled");
    sleep_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q[`PEDC_BIT_SLEEP_EN] && energy_q) |=> pwr_q == PEDC_PWR_ON)
        else $error("phy did not wake with energy");
    power_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        phy_power_down == $past(pwr_q == PEDC_PWR_SLEEP))
        else $error("power down output mismatch");
    wake_thres_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_threshold_low == $past(ctrl_q[`PEDC_BIT_WAKE_LOW]))
        else $error("threshold output mismatch");
    wake_normal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q[`PEDC_BIT_WAKE_LOW] |=> !wake_threshold_low)
        else $error("reduced threshold while not selected");
    force_link_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (speed_100 && ctrl_q[`PEDC_BIT_FORCE_LINK]) |=> link_up)
        else $error("forced link not up");
    force_slow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!speed_100 && !link_partner_ok) |=> !link_up)
        else $error("link up without partner or forcing");
    link_normal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (link_partner_ok && pwr_q == PEDC_PWR_ON) |=> link_up)
        else $error("normal link not up");
    link_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (link_prev_q != link_now) |=> status_q[0])
        else $error("link change not flagged");
    energy_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr == `PEDC_OFF_PHY_CONTROL_TWO) |=> hrdata[1] == $past(energy_q))
        else $error("energy flag read mismatch");
    reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q & ~`PEDC_CTRL_WMASK) == 16'h0000)
        else $error("reserved bit set");
    ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> ctrl_q == $past(hwdata[15:0] & `PEDC_CTRL_WMASK))
        else $error("control write not stored");
    ctrl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_ctrl |=> $stable(ctrl_q))
        else $error("control changed without a write");
    read_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr == `PEDC_OFF_PHY_CONTROL_TWO) |=>
        (hrdata[31:16] == 16'h0000 && (hrdata[15:0] & ~(`PEDC_CTRL_WMASK | 16'h0002)) == 16'h0000))
        else $error("reserved bit read as one");
    mask_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_mask |=> mask_q == $past(hwdata[`PEDC_IRQ_BITS-1:0]))
        else $error("mask write not stored");
    unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && !wr_ctrl && !wr_status && !wr_mask) |=> ($stable(ctrl_q) && $stable(mask_q)))
        else $error("unmapped write changed a register");
    energy_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_sync_q[2] && rx_sync_q[1]) |=> energy_q)
        else $error("energy flag not set");
    energy_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_sync_q[2] != rx_sync_q[1]) |=> $stable(energy_q))
        else $error("energy flag moved before stages agree");
    energy_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!energy_prev_q && energy_q) |=> status_q[1])
        else $error("energy rise not flagged");
    status_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_status |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("status bit lost without a clear");
    status_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_status && events == 3'h0) |=> status_q == $past(status_q & ~hwdata[`PEDC_IRQ_BITS-1:0]))
        else $error("status clear mismatch");
    energy_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!rx_sync_q[2] && !rx_sync_q[1]) |=> !energy_q)
        else $error("energy flag not cleared");
    energy_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (energy_prev_q && !energy_q) |=> status_q[2])
        else $error("energy fall not flagged");
    tx_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !link_now |=> !transmit_allowed)
        else $error("transmit while unlinked");
    tx_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwr_q == PEDC_PWR_SLEEP && !ctrl_q[`PEDC_BIT_FORCE_LINK]) |=> !transmit_allowed)
        else $error("transmit granted while asleep");
    tx_grant_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (transmit_request && link_now) |=> transmit_allowed)
        else $error("linked request not granted");
    tx_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !transmit_request |=> !transmit_allowed)
        else $error("grant without a request");
    tx_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_wait_q == 4'hf && !link_now) |=> !transmit_allowed)
        else $error("long held request released while unlinked");

    sleep_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(phy_power_down));
    wake_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(phy_power_down));
    forced_c: cover property (@(posedge hclk) disable iff (!hresetn) ctrl_q[`PEDC_BIT_FORCE_LINK] && link_up);
    energy_fall_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(energy_q));
    tx_held_c: cover property (@(posedge hclk) disable iff (!hresetn) tx_wait_q == 4'hf);
endmodule

// >>> pedc_link_partner.sv
`timescale 1ns/10ps
module pedc_link_partner (
    // clock
    input wire logic hclk,
    // cable state set by the bench
    input wire logic plugged,
    // phy side
    output logic receive_pair_input = 1'b0,
    output logic link_partner_ok = 1'b0
);
    logic [2:0] age_q = 3'h0;
    // link comes later than energy, as a real partner needs pulses before it links
    always_ff @(posedge hclk) begin
        receive_pair_input <= plugged;
        age_q <= !plugged ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
        link_partner_ok <= (age_q == 3'h7);
    end
endmodule

// >>> test_pedc_top.sv
`timescale 1ns/10ps
`include "pedc_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module test_pedc_top;
    import pedc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, plugged, speed_100, transmit_request;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic receive_pair_input, link_partner_ok, phy_power_down, wake_threshold_low, link_up, transmit_allowed, irq;
    int bad_count = 0;
    int total_checks = 0;
    localparam logic [31:0] WV [5] = '{32'hffffffff, 32'h00002000, 32'h00000800, 32'h00000004, 32'h00000000};
    localparam logic [31:0] EV [5] = '{32'h00002806, 32'h00002002, 32'h00000802, 32'h00000006, 32'h00000002};
    assign hready = hreadyout;
    pedc_top pedc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .receive_pair_input(receive_pair_input), .speed_100(speed_100),
        .link_partner_ok(link_partner_ok), .transmit_request(transmit_request), .phy_power_down(phy_power_down),
        .wake_threshold_low(wake_threshold_low), .link_up(link_up), .transmit_allowed(transmit_allowed), .irq(irq));
    pedc_link_partner pedc_link_partner_i (.hclk(hclk), .plugged(plugged),
        .receive_pair_input(receive_pair_input), .link_partner_ok(link_partner_ok));
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // entered just after a rising edge; returns just after the data phase edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        logic [31:0] r;
        hresetn = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
        hwdata = 32'h0; plugged = 1'b1; speed_100 = 1'b0; transmit_request = 1'b0;
        tick(10);
        hresetn <= 1'b1;
        tick(1);
        xfer(1'b0, `PEDC_OFF_PHY_CONTROL_TWO, 32'h0, r);
        `CHK(r, 32'h00000002)
        `CHK(hreadyout, 1'b1)
        `CHK(hresp, 1'b0)
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, `PEDC_OFF_PHY_CONTROL_TWO, WV[i], r);
            xfer(1'b0, `PEDC_OFF_PHY_CONTROL_TWO, 32'h0, r);
            `CHK(r, EV[i])
            `CHK(wake_threshold_low, EV[i][11])
        end
        plugged <= 1'b0;
        tick(10);
        xfer(1'b0, `PEDC_OFF_PHY_CONTROL_TWO, 32'h0, r);
        `CHK(r, 32'h00000000)
        `CHK(phy_power_down, 1'b0)
        xfer(1'b1, `PEDC_OFF_PHY_CONTROL_TWO, 32'h00002000, r);
        transmit_request <= 1'b1;
        tick(6);
        `CHK(phy_power_down, 1'b1)
        `CHK(transmit_allowed, 1'b0)
        xfer(1'b0, `PEDC_OFF_PHY_STATUS, 32'h0, r);
        `CHK(r, 32'h00000001)
        plugged <= 1'b1;
        tick(20);
        `CHK(phy_power_down, 1'b0)
        `CHK(transmit_allowed, 1'b1)
        xfer(1'b0, `PEDC_OFF_PHY_STATUS, 32'h0, r);
        `CHK(r, 32'h00000006)
        xfer(1'b0, `PEDC_OFF_PHY_CONTROL_TWO, 32'h0, r);
        `CHK(r, 32'h00002002)
        plugged <= 1'b0; speed_100 <= 1'b1; transmit_request <= 1'b0;
        xfer(1'b1, `PEDC_OFF_PHY_CONTROL_TWO, 32'h00000004, r);
        tick(10);
        `CHK(link_up, 1'b1)
        speed_100 <= 1'b0;
        tick(3);
        `CHK(link_up, 1'b0)
        xfer(1'b1, `PEDC_OFF_IRQ_MASK, 32'h00000002, r);
        xfer(1'b1, `PEDC_OFF_IRQ_STATUS, 32'h00000007, r);
        tick(1);
        `CHK(irq, 1'b0)
        plugged <= 1'b1;
        tick(10);
        `CHK(irq, 1'b1)
        xfer(1'b1, `PEDC_OFF_IRQ_STATUS, 32'h00000002, r);
        tick(1);
        `CHK(irq, 1'b0)
        xfer(1'b1, `PEDC_OFF_IRQ_MASK, 32'h00000000, r);
        plugged <= 1'b0;
        tick(10);
        plugged <= 1'b1;
        tick(10);
        `CHK(irq, 1'b0)
        xfer(1'b0, `PEDC_OFF_IRQ_STATUS, 32'h0, r);
        `CHK(r[1], 1'b1)
        `CHK(r[2], 1'b1)
        xfer(1'b1, 12'h100, 32'hffffffff, r);
        xfer(1'b0, 12'h100, 32'h0, r);
        `CHK(r, 32'h00000000)
        xfer(1'b1, `PEDC_OFF_PHY_CONTROL_TWO, 32'h00000800, r);
        hresetn <= 1'b0;
        tick(2);
        `CHK(wake_threshold_low, 1'b0)
        hresetn <= 1'b1;
        tick(1);
        // reset forgets everything, so the host writes the setup again
        xfer(1'b1, `PEDC_OFF_PHY_CONTROL_TWO, 32'h00002000, r);
        xfer(1'b0, `PEDC_OFF_PHY_CONTROL_TWO, 32'h0, r);
        `CHK(r, 32'h00002002)
        report_and_stop();
    end
endmodule
